// >>> cbb_pkg.sv
package cbb_pkg;
    // Opcodes of the two branches
    localparam logic [7:0] CBB_OP_BIT_CLR = 8'h10;
    localparam logic [7:0] CBB_OP_CARRY = 8'h40;
    // Instruction lengths in bytes
    localparam logic [15:0] CBB_LEN_BIT_CLR = 16'h0003;
    localparam logic [15:0] CBB_LEN_CARRY = 16'h0002;
    // Machine cycles per instruction
    localparam int CBB_MACH_CYCLES = 2;
    // Bit address split: bit 7 selects the special-register space
    localparam int CBB_BA_SFR_POS = 7;
    // Sequencer states, one-hot
    typedef enum logic [2:0] {
        CBB_IDLE = 3'b001,
        CBB_EXEC = 3'b010,
        CBB_DONE = 3'b100
    } cbb_state_t;
    // Decoded instruction issued by the core
    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] bit_addr;
        logic [7:0] disp_bit;
        logic [7:0] disp_carry;
        logic [15:0] pc;
    } cbb_instr_t;
    // Result handed back to the core
    typedef struct packed {
        logic taken;
        logic [15:0] next_pc;
        logic clr_en;
        logic [7:0] clr_addr;
    } cbb_result_t;
endpackage

// >>> cbb_target.sv
`timescale 1ns/1ps
// Registered relative-target adder
module cbb_target
    import cbb_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Operands
    input wire logic [15:0] pc_i,
    input wire logic [15:0] len_i,
    input wire logic [7:0] disp_i,
    input wire logic take_i,
    // Result
    output logic [15:0] next_pc_o
);
    logic [15:0] seq_pc; // Address of following instruction
    logic [15:0] next_pc_d;
    logic [15:0] next_pc_q;

    // Advance first, then add sign-extended offset when taken
    always_comb begin
        seq_pc = pc_i + len_i;
        next_pc_d = take_i ? seq_pc + {{8{disp_i[7]}}, disp_i} : seq_pc;
    end

    // Register the target
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            next_pc_q <= 16'h0000;
        end else begin
            next_pc_q <= next_pc_d;
        end
    end

    assign next_pc_o = next_pc_q;
endmodule // cbb_target

// >>> cbb_branch_unit.sv
`timescale 1ns/1ps
module cbb_branch_unit
    import cbb_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Instruction issue
    input wire logic issue_i,
    input wire cbb_instr_t instr_i,
    // Bit sources
    input wire logic bit_mem_i,
    input wire logic bit_pin_i,
    input wire logic bit_latch_i,
    input wire logic bit_is_port_i,
    input wire logic carry_i,
    // Result
    output logic busy_o,
    output logic done_o,
    output logic taken_o,
    output logic [15:0] next_pc_o,
    output logic clr_en_o,
    output logic [7:0] clr_addr_o
);
    // Reset release synchroniser
    logic rst_s1_q;
    logic rst_s2_q;
    logic rst_n;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    assign rst_n = rst_s2_q;

    // Recognised opcode
    function automatic logic is_bit_clr(input logic [7:0] op);
        return op == CBB_OP_BIT_CLR;
    endfunction
    function automatic logic is_carry(input logic [7:0] op);
        return op == CBB_OP_CARRY;
    endfunction

    // Sequencer state
    cbb_state_t state_q, state_d;
    logic is_bc_q, is_bc_d; // Current op is bit-clear
    logic take_q, take_d; // Branch decision
    logic [7:0] disp_q, disp_d; // Latched displacement
    logic [15:0] pc_q, pc_d; // Latched opcode address
    logic [7:0] addr_q, addr_d; // Latched bit address
    logic done_q, done_d;
    logic clr_q, clr_d;
    logic busy_q, busy_d; // Registered not-idle flag, so busy_o leaves a flop
    logic tested_bit; // Bit value seen by the test
    logic [15:0] tgt_pc; // From adder

    // Pick the bit source
    always_comb begin
        tested_bit = bit_is_port_i ? bit_latch_i : bit_mem_i;
    end

    // Next-state logic; one cycle decode, one cycle finish
    always_comb begin
        state_d = state_q;
        is_bc_d = is_bc_q;
        take_d = take_q;
        disp_d = disp_q;
        pc_d = pc_q;
        addr_d = addr_q;
        done_d = 1'b0;
        clr_d = 1'b0;
        case (state_q)
            CBB_IDLE: begin
                if (issue_i && is_bit_clr(instr_i.opcode)) begin
                    state_d = CBB_EXEC;
                    is_bc_d = 1'b1;
                    take_d = tested_bit;
                    disp_d = instr_i.disp_bit;
                    pc_d = instr_i.pc;
                    addr_d = instr_i.bit_addr;
                end else if (issue_i && is_carry(instr_i.opcode)) begin
                    state_d = CBB_EXEC;
                    is_bc_d = 1'b0;
                    take_d = carry_i;
                    disp_d = instr_i.disp_carry;
                    pc_d = instr_i.pc;
                    addr_d = 8'h00;
                end
            end
            CBB_EXEC: begin
                state_d = CBB_DONE;
            end
            CBB_DONE: begin
                // Second machine cycle: publish
                state_d = CBB_IDLE;
                done_d = 1'b1;
                clr_d = is_bc_q && take_q;
            end
            default: begin
                state_d = CBB_IDLE;
            end
        endcase
        // Busy follows the state we are about to enter
        busy_d = (state_d != CBB_IDLE);
    end

    // Register sequencer; flags have no port here, so untouched
    // no flag writes
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= CBB_IDLE;
            is_bc_q <= 1'b0;
            take_q <= 1'b0;
            disp_q <= 8'h00;
            pc_q <= 16'h0000;
            addr_q <= 8'h00;
            done_q <= 1'b0;
            clr_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            state_q <= state_d;
            is_bc_q <= is_bc_d;
            take_q <= take_d;
            disp_q <= disp_d;
            pc_q <= pc_d;
            addr_q <= addr_d;
            done_q <= done_d;
            clr_q <= clr_d;
            busy_q <= busy_d;
        end
    end

    // Target adder; length picks +3 or +2
    // advance then add
    cbb_target u_target (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .pc_i(pc_q),
        .len_i(is_bc_q ? CBB_LEN_BIT_CLR : CBB_LEN_CARRY),
        .disp_i(disp_q),
        .take_i(take_q),
        .next_pc_o(tgt_pc)
    );

    // Output registers aligned with done
    logic taken_q, taken_d;
    logic [15:0] npc_q, npc_d;
    logic [7:0] caddr_q, caddr_d;

    always_comb begin
        taken_d = taken_q;
        npc_d = npc_q;
        caddr_d = caddr_q;
        if (state_q == CBB_DONE) begin
            taken_d = take_q;
            npc_d = tgt_pc;
            caddr_d = addr_q;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            taken_q <= 1'b0;
            npc_q <= 16'h0000;
            caddr_q <= 8'h00;
        end else begin
            taken_q <= taken_d;
            npc_q <= npc_d;
            caddr_q <= caddr_d;
        end
    end

    assign busy_o = busy_q;
    assign done_o = done_q;
    assign taken_o = taken_q;
    assign next_pc_o = npc_q;
    assign clr_en_o = clr_q;
    assign clr_addr_o = caddr_q;

    // Assertions
    sequence s_issue_bc;
        issue_i && state_q == CBB_IDLE && instr_i.opcode == CBB_OP_BIT_CLR;
    endsequence
    sequence s_issue_c;
        issue_i && state_q == CBB_IDLE && instr_i.opcode == CBB_OP_CARRY;
    endsequence
    // Either branch accepted
    sequence s_issue_any;
        issue_i && state_q == CBB_IDLE
            && (instr_i.opcode == CBB_OP_BIT_CLR || instr_i.opcode == CBB_OP_CARRY);
    endsequence

    property p_bc_clear;
        @(posedge clk_i) disable iff (!rst_n)
        s_issue_bc ##0 (bit_is_port_i ? bit_latch_i : bit_mem_i) |-> ##3 clr_en_o && taken_o;
    endproperty
    a_bc_clear: assert property (p_bc_clear) else $error("set bit not cleared");

    property p_bc_noclr;
        @(posedge clk_i) disable iff (!rst_n)
        s_issue_bc ##0 !(bit_is_port_i ? bit_latch_i : bit_mem_i) |-> ##3 !clr_en_o && !taken_o;
    endproperty
    a_bc_noclr: assert property (p_bc_noclr) else $error("zero bit written");

    property p_bc_pc;
        @(posedge clk_i) disable iff (!rst_n)
        s_issue_bc |-> ##3 next_pc_o == 16'(($past(instr_i.pc, 3)) + 16'h0003
            + (taken_o ? {{8{$past(instr_i.disp_bit[7], 3)}}, $past(instr_i.disp_bit, 3)}
            : 16'h0000));
    endproperty
    a_bc_pc: assert property (p_bc_pc) else $error("bit-clear target wrong");

    property p_latch;
        @(posedge clk_i) disable iff (!rst_n)
        s_issue_bc ##0 bit_is_port_i |-> ##3 taken_o == $past(bit_latch_i, 3);
    endproperty
    a_latch: assert property (p_latch) else $error("port bit not from latch");

    property p_two_cycles;
        @(posedge clk_i) disable iff (!rst_n)
        s_issue_any |-> ##1 busy_o [*2] ##1 (done_o && !busy_o);
    endproperty
    a_two_cycles: assert property (p_two_cycles) else $error("wrong cycle count");

    property p_carry;
        @(posedge clk_i) disable iff (!rst_n)
        s_issue_c |-> ##3 taken_o == $past(carry_i, 3) && !clr_en_o;
    endproperty
    a_carry: assert property (p_carry) else $error("carry decision wrong");

    property p_c_pc;
        @(posedge clk_i) disable iff (!rst_n)
        s_issue_c |-> ##3 next_pc_o == 16'(($past(instr_i.pc, 3)) + 16'h0002
            + (taken_o ? {{8{$past(instr_i.disp_carry[7], 3)}}, $past(instr_i.disp_carry, 3)}
            : 16'h0000));
    endproperty
    a_c_pc: assert property (p_c_pc) else $error("carry target wrong");

    property p_idle_quiet;
        @(posedge clk_i) disable iff (!rst_n)
        !done_o |-> !clr_en_o;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("stray clear");
endmodule // cbb_branch_unit

// >>> conditional_bit_branch_unit_test.sv
`timescale 1ns/1ps
module conditional_bit_branch_unit_test;
    import cbb_pkg::*;
    // Stimulus, all idle at time zero
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic issue_i = 1'b0;
    cbb_instr_t instr_i = '0;
    logic bit_mem_i = 1'b0;
    logic bit_pin_i = 1'b0;
    logic bit_latch_i = 1'b0;
    logic bit_is_port_i = 1'b0;
    logic carry_i = 1'b0;
    // Observed results
    logic busy_o;
    logic done_o;
    logic taken_o;
    logic [15:0] next_pc_o;
    logic clr_en_o;
    logic [7:0] clr_addr_o;
    // Score keeping
    int fails = 0;
    int tests_run = 0;

    // 25 MHz machine clock
    always #20 clk_i = ~clk_i;

    cbb_branch_unit cbb_branch_unit_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .issue_i(issue_i),
        .instr_i(instr_i), .bit_mem_i(bit_mem_i), .bit_pin_i(bit_pin_i),
        .bit_latch_i(bit_latch_i), .bit_is_port_i(bit_is_port_i), .carry_i(carry_i),
        .busy_o(busy_o), .done_o(done_o), .taken_o(taken_o), .next_pc_o(next_pc_o),
        .clr_en_o(clr_en_o), .clr_addr_o(clr_addr_o));

    // One compare for every result, widened to 16 bits
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // Verdict and end of run
    task automatic summarize();
        $display("compares %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Issue one branch and judge its result; hold keeps a second request up while busy
    task automatic run(input logic [7:0] op, input logic [15:0] pc, input logic [7:0] disp,
        input logic mem, input logic latch, input logic port, input logic cy, input logic hold);
        logic bit_op;
        logic tk;
        logic [15:0] exp_pc;
        int n;
        bit_op = (op == CBB_OP_BIT_CLR);
        tk = bit_op ? (port ? latch : mem) : cy;
        exp_pc = pc + (bit_op ? CBB_LEN_BIT_CLR : CBB_LEN_CARRY);
        if (tk) begin
            exp_pc = exp_pc + {{8{disp[7]}}, disp};
        end
        @(posedge clk_i);
        issue_i <= 1'b1;
        // Unused offset field is the inverse, so a field mix-up shows
        instr_i <= '{op, pc[7:0] ^ 8'h5a, bit_op ? disp : ~disp, bit_op ? ~disp : disp, pc};
        bit_mem_i <= mem;
        bit_latch_i <= latch;
        // Pin always disagrees with the latch
        bit_pin_i <= ~latch;
        bit_is_port_i <= port;
        carry_i <= cy;
        @(posedge clk_i);
        // Refused request: the other opcode, offered while busy
        issue_i <= hold;
        instr_i.opcode <= bit_op ? CBB_OP_CARRY : CBB_OP_BIT_CLR;
        n = 0;
        do begin
            @(posedge clk_i);
            // Keep the refused request up through both busy edges
            if (n > 0) begin
                issue_i <= 1'b0;
            end
            #1;
            n++;
            if (n == 1) begin
                chk("busy", 16'h0001, {15'h0000, busy_o});
            end
        end while (done_o !== 1'b1 && n < 8);
        // Done shows right after the second clock edge past the edge that took the issue
        chk("latency", 16'(CBB_MACH_CYCLES), 16'(n));
        chk("busy at done", 16'h0000, {15'h0000, busy_o});
        chk("taken", {15'h0000, tk}, {15'h0000, taken_o});
        chk("next pc", exp_pc, next_pc_o);
        chk("clear", {15'h0000, bit_op & tk}, {15'h0000, clr_en_o});
        if (bit_op && tk) begin
            chk("clear addr", {8'h00, pc[7:0] ^ 8'h5a}, {8'h00, clr_addr_o});
        end
        @(posedge clk_i);
        #1;
        // A refused request must not have started a second run
        chk("done pulse", 16'h0000, {13'h0000, busy_o, done_o, clr_en_o});
    endtask

    // Unknown opcode never completes
    task automatic t_ignored();
        int seen;
        seen = 0;
        @(posedge clk_i);
        issue_i <= 1'b1;
        instr_i.opcode <= 8'h20;
        @(posedge clk_i);
        issue_i <= 1'b0;
        repeat (6) begin
            @(posedge clk_i);
            #1;
            seen += int'(done_o === 1'b1);
        end
        chk("ignored op", 16'h0000, 16'(seen));
    endtask

    // Watchdog, far beyond the expected run
    initial begin
        #(40 * 3000);
        fails++;
        summarize();
    end

    initial begin
        repeat (4) @(posedge clk_i);
        chk("reset done", 16'h0000, {13'h0000, busy_o, done_o, clr_en_o});
        chk("reset pc", 16'h0000, next_pc_o);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        // Bit source cases: memory one/zero, latch one/zero against pin
        run(CBB_OP_BIT_CLR, 16'h1000, 8'h10, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        run(CBB_OP_BIT_CLR, 16'h1000, 8'h10, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
        run(CBB_OP_BIT_CLR, 16'h2000, 8'hf0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
        run(CBB_OP_BIT_CLR, 16'h2000, 8'h7f, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
        run(CBB_OP_BIT_CLR, 16'hfffc, 8'h05, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
        // Carry cases, backward, not taken, forward with wrap, backward
        run(CBB_OP_CARRY, 16'h0010, 8'h80, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
        run(CBB_OP_CARRY, 16'h0010, 8'h80, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        run(CBB_OP_CARRY, 16'hfffe, 8'h01, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
        run(CBB_OP_CARRY, 16'h0003, 8'hfc, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
        t_ignored();
        summarize();
    end
endmodule // conditional_bit_branch_unit_test
